// File: rtl/pio_cfg.svh
/*
  Address map, reset values and fixed figures of the parallel port block.
  Assumes a 16-bit byte address and an 8-bit data path on the register port.
*/
`ifndef PIO_CFG_SVH
`define PIO_CFG_SVH

// per-port direction and data registers, port k at base + stride * k
`define PIO_DDR_BASE 16'hffb0
`define PIO_VAL_BASE 16'hffb2
`define PIO_PORT_STRIDE 16'h0004
// pull-up control, one byte per pull-up port, first at the base
`define PIO_PCR_BASE 16'hffac
// auxiliary function enables, one byte per port
`define PIO_AUX_BASE 16'hff80

// reset values
`define PIO_VAL_RESET 8'h00
`define PIO_PCR_RESET 8'h00
`define PIO_AUX_RESET 8'h00
`define PIO_DDR_FULL_EXP 8'hff
`define PIO_DDR_OTHER 8'h00

// read answers
`define PIO_DDR_READ 8'hff
`define PIO_UNMAPPED_READ 8'h00

// port geometry, index 0 is the first port
`define PIO_NUM_PORTS 9
`define PIO_LOW_ADDR_PORT 0
`define PIO_HIGH_ADDR_PORT 1
`define PIO_DATA_BUS_PORT 2
`define PIO_NARROW3_PORT 4
`define PIO_INPUT_ONLY_PORT 6
`define PIO_NARROW7_PORT 7
`define PIO_NUM_PULL_PORTS 3

`endif

// File: rtl/pio_pkg.sv
/*
  Types shared by the parallel port block: operating modes and the
  bundles carried on the register port and the external bus side.
  Assumes the user writes every reference as pio_pkg::name.
*/
package pio_pkg;

  // operating mode strapped at reset
  typedef enum logic [1:0] {
    pio_mode_full_exp = 2'b01,
    pio_mode_sel_exp = 2'b10,
    pio_mode_single = 2'b11
  } pio_mode_type;

  // one register access from the cpu side
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } pio_bus_req_type;

  // external bus values offered to the expanded-mode pins
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] dout;
    logic doe;
  } pio_ext_type;

endpackage

// File: rtl/pio_port.sv
/*
  One parallel port: output latch, direction, optional pull-up control and
  auxiliary enables, plus the pin drive selection. Outputs are combinational;
  the instantiating core registers everything that leaves the block.
  Assumes pins are synchronous to mclk.
*/
`timescale 1ns/1ps
`include "pio_cfg.svh"

module pio_port #(
  parameter int W = 8,
  parameter bit HAS_DDR = 1'b1,
  parameter bit HAS_PULL = 1'b0
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic init,
  input wire logic [W-1:0] ddr_init,
  input wire logic wr_val,
  input wire logic wr_ddr,
  input wire logic wr_pcr,
  input wire logic wr_aux,
  input wire logic [7:0] wdata,
  input wire logic [W-1:0] pin_in,
  input wire logic [W-1:0] aux_out,
  input wire logic [W-1:0] aux_oe,
  input wire logic [W-1:0] ovr_en,
  input wire logic ovr_by_dir,
  input wire logic [W-1:0] ovr_out,
  input wire logic [W-1:0] ovr_oe,
  output logic [7:0] val_read,
  output logic [W-1:0] drive_out,
  output logic [W-1:0] drive_en,
  output logic [W-1:0] pull_en,
  output logic [7:0] aux_read
);

  logic [W-1:0] latch;
  logic [W-1:0] dir;
  logic [W-1:0] pcr;
  logic [W-1:0] aux_en;
  logic [W-1:0] take;

  if (W < 1 || W > 8) begin : g_bad_width
    $error("pio_port width must be 1 to 8");
  end

  // output latch keeps the last write whatever the direction
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      latch <= W'(`PIO_VAL_RESET);
    end else if (wr_val) begin
      latch <= wdata[W-1:0];
    end
  end

  // direction: mode-dependent value loaded once after reset release
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dir <= W'(`PIO_DDR_OTHER);
    end else if (HAS_DDR && init) begin
      dir <= ddr_init;
    end else if (HAS_DDR && wr_ddr) begin
      dir <= wdata[W-1:0];
    end
  end

  // pull-up control exists only where the port offers it
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pcr <= W'(`PIO_PCR_RESET);
    end else if (HAS_PULL && wr_pcr) begin
      pcr <= wdata[W-1:0];
    end
  end

  // auxiliary function enables written by software
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      aux_en <= W'(`PIO_AUX_RESET);
    end else if (wr_aux) begin
      aux_en <= wdata[W-1:0];
    end
  end

  // bus override first, then auxiliary function, then plain port use
  always_comb begin
    take = ovr_en | (ovr_by_dir ? dir : '0);
    val_read = `PIO_UNMAPPED_READ;
    val_read[W-1:0] = (dir & latch) | (~dir & pin_in);
    aux_read = `PIO_UNMAPPED_READ;
    aux_read[W-1:0] = aux_en;
    drive_en = (take & ovr_oe) | (~take & aux_en & aux_oe) | (~take & ~aux_en & dir);
    drive_out = (take & ovr_out) | (~take & aux_en & aux_out) | (~take & ~aux_en & latch);
    if (!HAS_DDR) begin
      drive_en = '0;
    end
    pull_en = HAS_PULL ? (pcr & ~drive_en) : '0;
  end

endmodule // pio_port

// File: rtl/pio_core.sv
/*
  Parallel port core: nine ports behind a byte register port, with the
  expanded-mode address and data bus taking over the first three ports.
  Holds the mode capture, the address decode, the read answer mux, the
  expanded-mode takeover and the registers on every pin-side output.

  Register map, port index i counted from 0:
    direction    one byte per port at stride 4, none on the input-only port;
                 write-only, every read answers all ones
    value        one byte per port at stride 4, two above the direction byte;
                 reads give the latch on output pins, the live pin on inputs
    pull-up      one byte each for the three pull-up ports; reads give zero
    aux enable   one byte per port, read back as written
    other        writes are ignored and reads give zero
  Narrow ports use the low bits of a byte; the unused bits read zero and
  their pins never drive.

  Timing:
    a write lands at the edge that samples its strobe
    pins, pull-ups and auxiliary enables follow one edge after their cause
    read data stand in the cycle after the read strobe, zero otherwise
    mode and address-port direction load at the first edge after reset

  Hazards:
    a direction write to an address port in the first cycle after reset
    is lost to the mode load, so software waits one cycle
    the live pin level on a value read is the level at the strobe edge;
    pins are not resynchronised here

  Assumes a strap input for the mode, held steady around reset release,
  and pins that are synchronous to mclk. Pin wires are resolved outside.
*/
// Overview of operation
// - nine ports: six 8-bit, one 8-bit input, one 7-bit, one 3-bit
// - each port has a data register in the top register area
// - every port but the input-only one has a per-pin direction register
// - data writes land in a latch that drives output pins
// - reading an output pin returns the latch, not the pin level
// - reading an input pin returns the live pin level, no capture register
// - direction registers are write-only and read back as all ones
// - three 8-bit ports have software pull-ups, others have none
// - auxiliary functions act only once enabled, then override plain port use but not the bus takeover, and never drive the input-only port
// - one 8-bit input-only port without direction, pins also analog
// - selectable-address mode: low-address pin input at 0, address out at 1
// - low-address direction resets all ones in full expansion, else zeros
`timescale 1ns/1ps
`include "pio_cfg.svh"

module pio_core #(
  parameter int NPORT = `PIO_NUM_PORTS
) (
  input wire logic mclk,
  input wire logic rst,
  input wire pio_pkg::pio_bus_req_type bus_req,
  output logic [7:0] rd_data,
  input wire logic [1:0] mode_pins,
  output pio_pkg::pio_mode_type cur_mode,
  input wire pio_pkg::pio_ext_type ext,
  output logic [7:0] ext_data_in,
  input wire logic [NPORT-1:0][7:0] pin_in,
  output logic [NPORT-1:0][7:0] pin_out,
  output logic [NPORT-1:0][7:0] pin_oe_n,
  output logic [NPORT-1:0][7:0] pin_pullup,
  input wire logic [NPORT-1:0][7:0] aux_out,
  input wire logic [NPORT-1:0][7:0] aux_oe,
  output logic [NPORT-1:0][7:0] aux_en
);

  // refuse a port count the fixed layout below cannot serve
  if (NPORT != `PIO_NUM_PORTS) begin : g_bad_count
    $error("pio_core is laid out for exactly nine ports");
  end

  // value and direction bytes of one port must not share an address
  if (`PIO_PORT_STRIDE < 16'h0004 || `PIO_VAL_BASE == `PIO_DDR_BASE) begin : g_bad_stride
    $error("pio_core register map overlaps itself");
  end

  // the enable bytes must end before the pull-up bytes begin
  if (`PIO_AUX_BASE + 16'(NPORT) > `PIO_PCR_BASE) begin : g_bad_aux
    $error("pio_core enable bytes run into the pull-up bytes");
  end

  // the input-only and both narrow port roles must name ports that exist
  if (`PIO_INPUT_ONLY_PORT >= NPORT || `PIO_NARROW3_PORT >= NPORT || `PIO_NARROW7_PORT >= NPORT) begin : g_bad_roles
    $error("pio_core port roles fall outside the port range");
  end

  // the pull-up ports are the bus ports and never the input-only one
  if (`PIO_DATA_BUS_PORT >= `PIO_NUM_PULL_PORTS || `PIO_INPUT_ONLY_PORT < `PIO_NUM_PULL_PORTS) begin : g_bad_pull
    $error("pio_core pull-up ports must be the bus ports");
  end

  logic started;
  logic init;
  pio_pkg::pio_mode_type mode_now;
  logic [7:0] ddr_lo_init;

  // per-port answers and pin-side drive, padded to a byte
  logic [NPORT-1:0][7:0] val_rd_a;
  logic [NPORT-1:0][7:0] aux_rd_a;
  logic [NPORT-1:0][7:0] drv_out_a;
  logic [NPORT-1:0][7:0] drv_en_a;
  logic [NPORT-1:0][7:0] pull_a;
  logic [NPORT-1:0][7:0] ovr_en_a;
  logic [NPORT-1:0][7:0] ovr_out_a;
  logic [NPORT-1:0][7:0] ovr_oe_a;
  logic [NPORT-1:0] ovr_dir_a;

  // address hits, at most one bit set over all four sets
  logic [NPORT-1:0] hit_val;
  logic [NPORT-1:0] hit_ddr;
  logic [NPORT-1:0] hit_aux;
  logic [NPORT-1:0] hit_pcr;
  logic [7:0] next_rd_data;

  // one-cycle init pulse at the first edge after reset release;
  // the strap is never loaded under the asynchronous reset itself
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      started <= 1'b0;
    end else begin
      started <= 1'b1;
    end
  end

  assign init = ~started;

  // undefined strap codes fall back to single-chip operation
  always_comb begin
    case (mode_pins)
      2'b01: begin
        mode_now = pio_pkg::pio_mode_full_exp;
      end
      2'b10: begin
        mode_now = pio_pkg::pio_mode_sel_exp;
      end
      default: begin
        mode_now = pio_pkg::pio_mode_single;
      end
    endcase
  end

  // mode is caught once, at the init pulse, and held until next reset
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cur_mode <= pio_pkg::pio_mode_single;
    end else if (init) begin
      cur_mode <= mode_now;
    end
  end

  // address-port direction value taken from the strap during init
  assign ddr_lo_init = (mode_now == pio_pkg::pio_mode_full_exp) ? `PIO_DDR_FULL_EXP : `PIO_DDR_OTHER;

  // expanded-mode takeover of the address and data ports
  always_comb begin
    ovr_en_a = '0;
    ovr_out_a = '0;
    ovr_oe_a = '0;
    ovr_dir_a = '0;
    ovr_out_a[`PIO_LOW_ADDR_PORT] = ext.addr[7:0];
    ovr_out_a[`PIO_HIGH_ADDR_PORT] = ext.addr[15:8];
    ovr_oe_a[`PIO_LOW_ADDR_PORT] = 8'hff;
    ovr_oe_a[`PIO_HIGH_ADDR_PORT] = 8'hff;
    ovr_out_a[`PIO_DATA_BUS_PORT] = ext.dout;
    ovr_oe_a[`PIO_DATA_BUS_PORT] = {8{ext.doe}};
    case (cur_mode)
      pio_pkg::pio_mode_full_exp: begin
        // address pins always drive, data port carries the bus
        ovr_en_a[`PIO_LOW_ADDR_PORT] = 8'hff;
        ovr_en_a[`PIO_HIGH_ADDR_PORT] = 8'hff;
        ovr_en_a[`PIO_DATA_BUS_PORT] = 8'hff;
      end
      pio_pkg::pio_mode_sel_exp: begin
        // each address pin chosen by its own direction bit
        ovr_dir_a[`PIO_LOW_ADDR_PORT] = 1'b1;
        ovr_dir_a[`PIO_HIGH_ADDR_PORT] = 1'b1;
        ovr_en_a[`PIO_DATA_BUS_PORT] = 8'hff;
      end
      pio_pkg::pio_mode_single: begin
        ovr_en_a = '0;
      end
      default: begin
        ovr_en_a = '0;
      end
    endcase
  end

  // one port instance per port, geometry picked by index
  for (genvar i = 0; i < NPORT; i++) begin : g_port
    localparam int W = (i == `PIO_NARROW3_PORT) ? 3 : (i == `PIO_NARROW7_PORT) ? 7 : 8;
    localparam bit HAS_DDR = (i != `PIO_INPUT_ONLY_PORT);
    localparam bit HAS_PULL = (i < `PIO_NUM_PULL_PORTS);
    localparam logic [15:0] OFS = `PIO_PORT_STRIDE * 16'(i);

    logic [W-1:0] ddr_init_w;
    logic [W-1:0] drv_out_w;
    logic [W-1:0] drv_en_w;
    logic [W-1:0] pull_w;

    // address decode of this port's registers
    assign hit_val[i] = (bus_req.addr == `PIO_VAL_BASE + OFS);
    assign hit_ddr[i] = HAS_DDR && (bus_req.addr == `PIO_DDR_BASE + OFS);
    assign hit_aux[i] = (bus_req.addr == `PIO_AUX_BASE + 16'(i));
    assign hit_pcr[i] = HAS_PULL && (bus_req.addr == `PIO_PCR_BASE + 16'(i));

    // only the address ports have a mode-dependent direction reset
    assign ddr_init_w = (i == `PIO_LOW_ADDR_PORT || i == `PIO_HIGH_ADDR_PORT) ? ddr_lo_init[W-1:0] : W'(`PIO_DDR_OTHER);

    pio_port #(
      .W(W),
      .HAS_DDR(HAS_DDR),
      .HAS_PULL(HAS_PULL)
    ) u_port (
      .mclk(mclk),
      .rst(rst),
      .init(init),
      .ddr_init(ddr_init_w),
      .wr_val(bus_req.wr & hit_val[i]),
      .wr_ddr(bus_req.wr & hit_ddr[i]),
      .wr_pcr(bus_req.wr & hit_pcr[i]),
      .wr_aux(bus_req.wr & hit_aux[i]),
      .wdata(bus_req.wdata),
      .pin_in(pin_in[i][W-1:0]),
      .aux_out(aux_out[i][W-1:0]),
      .aux_oe(aux_oe[i][W-1:0]),
      .ovr_en(ovr_en_a[i][W-1:0]),
      .ovr_by_dir(ovr_dir_a[i]),
      .ovr_out(ovr_out_a[i][W-1:0]),
      .ovr_oe(ovr_oe_a[i][W-1:0]),
      .val_read(val_rd_a[i]),
      .drive_out(drv_out_w),
      .drive_en(drv_en_w),
      .pull_en(pull_w),
      .aux_read(aux_rd_a[i])
    );

    // pad narrow ports; missing pins never drive
    always_comb begin
      drv_out_a[i] = 8'h00;
      drv_en_a[i] = 8'h00;
      pull_a[i] = 8'h00;
      drv_out_a[i][W-1:0] = drv_out_w;
      drv_en_a[i][W-1:0] = drv_en_w;
      pull_a[i][W-1:0] = pull_w;
    end
  end

  // read answer mux; only one address can hit at a time
  always_comb begin
    next_rd_data = `PIO_UNMAPPED_READ;
    for (int k = 0; k < NPORT; k++) begin
      if (hit_val[k]) begin
        next_rd_data = val_rd_a[k];
      end
      if (hit_ddr[k]) begin
        next_rd_data = `PIO_DDR_READ;
      end
      if (hit_aux[k]) begin
        next_rd_data = aux_rd_a[k];
      end
    end
    for (int k = 0; k < NPORT; k++) begin
      if (hit_pcr[k]) begin
        next_rd_data = 8'h00;
      end
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rd_data <= `PIO_UNMAPPED_READ;
    end else if (bus_req.rd) begin
      rd_data <= next_rd_data;
    end else begin
      rd_data <= `PIO_UNMAPPED_READ;
    end
  end

  // pin drive registered; enable is active low while the pin is driven
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pin_out <= '0;
      pin_oe_n <= '1;
    end else begin
      pin_out <= drv_out_a;
      pin_oe_n <= ~drv_en_a;
    end
  end

  // pull-up enables, only on input pins of the pull-up ports
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pin_pullup <= '0;
    end else begin
      pin_pullup <= pull_a;
    end
  end

  // auxiliary enables handed to the peripherals that own those pins
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      aux_en <= '0;
    end else begin
      aux_en <= aux_rd_a;
    end
  end

  // data-bus port input towards the cpu side of the external bus
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ext_data_in <= 8'h00;
    end else begin
      ext_data_in <= pin_in[`PIO_DATA_BUS_PORT];
    end
  end

endmodule // pio_core

// File: test/pio_core_chk.sv
/*
  Checker for the parallel port core, watching only the core's ports.
  Assumes one clock, mclk, and an asynchronous active-high rst.
*/
`timescale 1ns/1ps
module pio_core_chk #(
  parameter int NPORT = 9
) (
  input wire logic mclk,
  input wire logic rst,
  input wire pio_pkg::pio_bus_req_type bus_req,
  input wire logic [7:0] rd_data,
  input wire pio_pkg::pio_mode_type cur_mode,
  input wire pio_pkg::pio_ext_type ext,
  input wire logic [NPORT-1:0][7:0] pin_out,
  input wire logic [NPORT-1:0][7:0] pin_oe_n,
  input wire logic [NPORT-1:0][7:0] pin_pullup
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // mode must hold two samples so the pins were computed in that mode
  full_addr_a: assert property (cur_mode == pio_pkg::pio_mode_full_exp && $past(cur_mode) == cur_mode
    |-> pin_out[1:0] == $past(ext.addr) && pin_oe_n[1:0] == 16'h0000) else $error("address not driven");
  sel_addr_a: assert property (cur_mode == pio_pkg::pio_mode_sel_exp && $past(cur_mode) == cur_mode
    |-> ((pin_out[1:0] ^ $past(ext.addr)) & ~pin_oe_n[1:0]) == 16'h0000) else $error("bad address bit");
  data_bus_a: assert property (cur_mode != pio_pkg::pio_mode_single && $past(cur_mode) == cur_mode && $past(ext.doe)
    |-> pin_oe_n[2] == 8'h00 && pin_out[2] == $past(ext.dout)) else $error("data bus not driven");
  input_only_a: assert property (pin_oe_n[6] == 8'hff) else $error("input port drives");
  narrow_port_a: assert property (pin_oe_n[4][7:3] == 5'h1f && pin_oe_n[7][7]) else $error("missing pin driven");
  pull_none_a: assert property (pin_pullup[8:3] == '0) else $error("pull-up on wrong port");
  pull_input_a: assert property ((pin_pullup[0] & ~pin_oe_n[0]) == 8'h00) else $error("pull-up on output");
  dir_read_a: assert property (bus_req.rd && bus_req.addr == 16'hffb4 |=> rd_data == 8'hff)
    else $error("direction read not ones");
  unmapped_rd_a: assert property (bus_req.rd && bus_req.addr == 16'h0000 |=> rd_data == 8'h00)
    else $error("unmapped read not zero");
endmodule // pio_core_chk

// File: test/pio_pins.sv
/*
  Pin-side model: resolves each pin from the core's drive, the pull-up
  and an outside source. Assumes the bench supplies the outside values.
*/
`timescale 1ns/1ps
module pio_pins (
  input wire logic [8:0][7:0] pin_out,
  input wire logic [8:0][7:0] pin_oe_n,
  input wire logic [8:0][7:0] pin_pullup,
  input wire logic [8:0][7:0] ext_val,
  input wire logic [8:0][7:0] ext_en,
  output logic [8:0][7:0] pin_in
);
  logic [8:0][7:0] lvl;
  // an outside source beats a pull-up; a released line without one shows the inverse
  assign lvl = (ext_en & ext_val) | (~ext_en & (pin_pullup | ~ext_val));
  // a driving core wins over the outside source
  assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & lvl);
endmodule // pio_pins

// File: test/parallel_io_port_core_tb_top.sv
/*
  Self-checking bench for the parallel port core with the pin model.
  Assumes a 10 MHz mclk and register reads answered one cycle later.
*/
`timescale 1ns/1ps
module parallel_io_port_core_tb_top;
  logic mclk, rst, take;
  pio_pkg::pio_bus_req_type bus_req;
  logic [7:0] rd_data, ext_data_in, d, v, m;
  logic [1:0] mode_pins;
  pio_pkg::pio_mode_type cur_mode;
  pio_pkg::pio_ext_type ext;
  logic [8:0][7:0] pin_in, pin_out, pin_oe_n, pin_pullup, aux_out, aux_oe, aux_en, ext_val, ext_en;
  logic [7:0] q[$];
  int fails, n_tests, cyc;

  pio_core i_pio_core (.mclk(mclk), .rst(rst), .bus_req(bus_req), .rd_data(rd_data), .mode_pins(mode_pins),
    .cur_mode(cur_mode), .ext(ext), .ext_data_in(ext_data_in), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .pin_pullup(pin_pullup), .aux_out(aux_out), .aux_oe(aux_oe), .aux_en(aux_en));
  pio_pins i_pio_pins (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_pullup(pin_pullup), .ext_val(ext_val),
    .ext_en(ext_en), .pin_in(pin_in));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task wrap_up;
    if (fails == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task wr(input logic [15:0] a, input logic [7:0] x);
    @(posedge mclk);
    bus_req <= '{addr: a, wdata: x, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    bus_req.wr <= 1'b0;
  endtask

  // the expected answer is noted when the read is issued
  task rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge mclk);
    bus_req.addr <= a;
    bus_req.rd <= 1'b1;
    q.push_back(e);
    @(posedge mclk);
    bus_req.rd <= 1'b0;
  endtask

  task tick;
    repeat (2) @(posedge mclk);
    #10;
  endtask

  // strap is sampled just after release, so it is set while reset is high
  task start(input logic [1:0] s);
    rst <= 1'b1;
    mode_pins <= s;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    tick;
  endtask

  // read answer stands one cycle only, so compare mid-cycle after the read
  always @(posedge mclk) take <= bus_req.rd;
  always @(negedge mclk) begin
    if (take === 1'b1 && q.size() > 0) check(rd_data, q.pop_front());
  end

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      wrap_up();
    end
  end

  initial begin
    rst = 1'b1;
    take = 1'b0;
    mode_pins = 2'b11;
    bus_req = '0;
    fails = 0;
    n_tests = 0;
    cyc = 0;
    ext_en = '1;
    void'($urandom(32'h12fe80bc));
    for (int i = 0; i < 9; i++) begin
      aux_out[i] = $urandom;
      aux_oe[i] = $urandom;
      ext_val[i] = $urandom;
    end
    ext = '{addr: 16'($urandom), dout: 8'($urandom), doe: 1'b1};
    start(2'b01);
    tick;
    check({6'h00, cur_mode}, 8'h01);
    check(pin_oe_n[0], 8'h00);
    check(pin_oe_n[1], 8'h00);
    check(pin_out[0], ext.addr[7:0]);
    check(pin_out[1], ext.addr[15:8]);
    check(ext_data_in, ext.dout);
    ext.doe <= 1'b0;
    tick;
    check(pin_oe_n[2], 8'hff);
    ext.doe <= 1'b1;
    start(2'b10);
    check(pin_oe_n[0], 8'hff);
    wr(16'hffb0, 8'h0f);
    wr(16'hffb4, 8'hf0);
    tick;
    check(pin_oe_n[0], 8'hf0);
    check(pin_out[0] & 8'h0f, ext.addr[7:0] & 8'h0f);
    check(pin_oe_n[1], 8'h0f);
    check(pin_out[1] & 8'hf0, ext.addr[15:8] & 8'hf0);
    start(2'b00);
    check({6'h00, cur_mode}, 8'h03);
    check(pin_oe_n[0], 8'hff);
    start(2'b11);
    check(pin_oe_n[0], 8'hff);
    // every port but the input-only one: direction, latch, read-back
    for (int i = 0; i < 9; i++) begin
      m = (i == 4) ? 8'h07 : (i == 7) ? 8'h7f : 8'hff;
      d = $urandom;
      v = $urandom;
      if (i != 6) begin
        wr(16'hffb0 + 16'(i * 4), d);
        wr(16'hffb2 + 16'(i * 4), v);
        tick;
        check(pin_oe_n[i], ~(d & m));
        check(pin_out[i] & d & m, v & d & m);
        rd(16'hffb2 + 16'(i * 4), ((d & v) | (~d & ext_val[i])) & m);
        rd(16'hffb0 + 16'(i * 4), 8'hff);
      end
    end
    rd(16'hffca, ext_val[6]);
    rd(16'hffc8, 8'h00);
    wr(16'hffb0, 8'h00);
    ext_en[0] <= 8'h00;
    wr(16'hffac, 8'hff);
    tick;
    check(pin_pullup[0], 8'hff);
    rd(16'hffb2, 8'hff);
    wr(16'hff83, 8'hff);
    wr(16'hff86, 8'hff);
    tick;
    check(pin_out[3] & aux_oe[3], aux_out[3] & aux_oe[3]);
    check(pin_oe_n[3], ~aux_oe[3]);
    check(aux_en[3], 8'hff);
    check(pin_oe_n[6], 8'hff);
    rd(16'hff83, 8'hff);
    wr(16'h0000, 8'h5a);
    rd(16'h0000, 8'h00);
    repeat (3) @(posedge mclk);
    wrap_up();
  end
endmodule // parallel_io_port_core_tb_top

bind pio_core pio_core_chk #(.NPORT(NPORT)) i_pio_core_chk (.mclk(mclk), .rst(rst), .bus_req(bus_req),
  .rd_data(rd_data), .cur_mode(cur_mode), .ext(ext), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
  .pin_pullup(pin_pullup));
